/* File: rtl/oplc_core.sv */
// protection and limit configuration registers and limit dac steering
`timescale 1ns/10ps
`include "oplc_defs.svh"

// Overview of operation
// - current byte bit7 fixes on-state current limit
// - current protection detection only when bit6 set
// - bit5 enables current-protect esr/ese bit
// - bit4 together with bit5 loads ese 72 at reset, otherwise 8
// - bit3 makes current-protect error number 303
// - bit2 turns output off on current-protect
// - bit1 current measure error raises device error
// - bit0 current measure error shuts output down
// - code and error bytes accept 00..FF, selector keeps bits 4..0, read returns one byte
// - voltage byte bit7 fixes on-state voltage limit
// - voltage protection detection only when bit6 set
// - bit3 makes voltage-protect error number 304
// - bit2 turns output off on voltage-protect
// - bit1 voltage measure error raises device error
// - bit0 makes voltage device error turn off
// - selector bit4 uses off current code
// - selector bit3 uses off voltage code
// - current bit7 uses on current code
// - voltage bit7 uses on voltage code
// - limit code read returns stored dac code
// - selector bits 0/1 force maximum limit
module oplc_core
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire oplc_pkg::oplc_addr_type cfg_addr,
  input wire oplc_pkg::oplc_byte_type cfg_wdata,
  output oplc_pkg::oplc_byte_type cfg_rdata,
  output logic cfg_rvalid,
  input wire logic output_on_pin,
  input wire logic current_mode_pin,
  input wire logic curr_over_prot_pin,
  input wire logic volt_over_prot_pin,
  input wire logic curr_meas_err_pin,
  input wire logic volt_meas_err_pin,
  output oplc_pkg::oplc_byte_type curr_limit_dac,
  output oplc_pkg::oplc_byte_type volt_limit_dac,
  output oplc_pkg::oplc_byte_type ese_init,
  output logic esr_curr_prot,
  output logic error_pulse,
  output oplc_pkg::oplc_errnum_type error_number,
  output logic device_error,
  output logic force_output_off
);
  import oplc_pkg::*;

  // configuration bytes
  oplc_byte_type curr_err_q;
  oplc_byte_type curr_err_d;
  oplc_byte_type volt_err_q;
  oplc_byte_type volt_err_d;
  oplc_byte_type off_curr_q;
  oplc_byte_type off_curr_d;
  oplc_byte_type off_volt_q;
  oplc_byte_type off_volt_d;
  oplc_byte_type on_curr_q;
  oplc_byte_type on_curr_d;
  oplc_byte_type on_volt_q;
  oplc_byte_type on_volt_d;
  logic [4:0] off_sel_q;
  logic [4:0] off_sel_d;
  // read answer
  oplc_byte_type rdata_q;
  oplc_byte_type rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  // pin synchroniser chain and the previous synchronised level
  logic [5:0] sync1_q;
  logic [5:0] sync1_d;
  logic [5:0] sync2_q;
  logic [5:0] sync2_d;
  logic [5:0] sync_edge_q;
  logic [5:0] sync_edge_d;
  logic [3:0] pin_rise;
  // limit dac codes
  oplc_byte_type idac_q;
  oplc_byte_type idac_d;
  oplc_byte_type vdac_q;
  oplc_byte_type vdac_d;
  // event enable init value
  oplc_byte_type ese_q;
  oplc_byte_type ese_d;
  // event reporting
  logic esr_q;
  logic esr_d;
  logic errp_q;
  logic errp_d;
  oplc_errnum_type errnum_q;
  oplc_errnum_type errnum_d;
  logic deverr_q;
  logic deverr_d;
  logic off_q;
  logic off_d;
  // synchronised levels, rising edges and gated detections
  logic out_on;
  logic cur_mode;
  logic ip_rise;
  logic vp_rise;
  logic im_rise;
  logic vm_rise;
  logic ip_det;
  logic vp_det;
  logic im_det;
  logic vm_det;

  // register read mux, used for read data
  function automatic oplc_byte_type reg_read(input oplc_addr_type a);
    case (a)
      `OPLC_REG_CURR_ERR: reg_read = curr_err_q;
      `OPLC_REG_VOLT_ERR: reg_read = volt_err_q;
      `OPLC_REG_OFF_CURR: reg_read = off_curr_q;
      `OPLC_REG_OFF_VOLT: reg_read = off_volt_q;
      `OPLC_REG_ON_CURR: reg_read = on_curr_q;
      `OPLC_REG_ON_VOLT: reg_read = on_volt_q;
      `OPLC_REG_OFF_SEL: reg_read = {3'h0, off_sel_q};
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // next values of the two-flop synchronisers on the analog status pins
  always_comb
  begin
    sync1_d = {output_on_pin, current_mode_pin, curr_over_prot_pin,
               volt_over_prot_pin, curr_meas_err_pin, volt_meas_err_pin};
    sync2_d = sync1_q;
    sync_edge_d = sync2_q; // only the second flop and this previous-level copy feed any logic
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      sync_edge_q <= 6'h00;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      sync_edge_q <= sync_edge_d;
    end
  end

  // synchronised levels that steer the limit dacs
  assign out_on = sync2_q[5];
  assign cur_mode = sync2_q[4];

  // rising edges of the event pins, protect current at bit 3 down to
  // measure voltage at bit 0; a pin already high at reset release counts
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_rise
      assign pin_rise[gi] = sync2_q[gi] & ~sync_edge_q[gi];
    end
  endgenerate

  // named edges for the detection logic
  assign ip_rise = pin_rise[3];
  assign vp_rise = pin_rise[2];
  assign im_rise = pin_rise[1];
  assign vm_rise = pin_rise[0];

  // configuration byte writes and read answer
  always_comb
  begin
    curr_err_d = curr_err_q;
    volt_err_d = volt_err_q;
    off_curr_d = off_curr_q;
    off_volt_d = off_volt_q;
    on_curr_d = on_curr_q;
    on_volt_d = on_volt_q;
    off_sel_d = off_sel_q;
    if (cfg_wr)
    begin
      case (cfg_addr)
        `OPLC_REG_CURR_ERR: curr_err_d = cfg_wdata;
        `OPLC_REG_VOLT_ERR: volt_err_d = cfg_wdata;
        `OPLC_REG_OFF_CURR: off_curr_d = cfg_wdata;
        `OPLC_REG_OFF_VOLT: off_volt_d = cfg_wdata;
        `OPLC_REG_ON_CURR: on_curr_d = cfg_wdata;
        `OPLC_REG_ON_VOLT: on_volt_d = cfg_wdata;
        `OPLC_REG_OFF_SEL: off_sel_d = cfg_wdata[4:0];
        default: ;
      endcase
    end
    rvalid_d = cfg_rd;
    rdata_d = cfg_rd ? reg_read(cfg_addr) : rdata_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      curr_err_q <= 8'h00;
      volt_err_q <= 8'h00;
      off_curr_q <= `OPLC_CODE_STD_CURR;
      off_volt_q <= `OPLC_CODE_STD_VOLT;
      on_curr_q <= `OPLC_CODE_STD_CURR;
      on_volt_q <= `OPLC_CODE_STD_VOLT;
      off_sel_q <= 5'h00;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      curr_err_q <= curr_err_d;
      volt_err_q <= volt_err_d;
      off_curr_q <= off_curr_d;
      off_volt_q <= off_volt_d;
      on_curr_q <= on_curr_d;
      on_volt_q <= on_volt_d;
      off_sel_q <= off_sel_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // detection gated by protection enables and operating mode
  assign ip_det = ip_rise & curr_err_q[`OPLC_BIT_PROT_EN];
  assign vp_det = vp_rise & volt_err_q[`OPLC_BIT_PROT_EN];
  assign im_det = im_rise & cur_mode;
  assign vm_det = vm_rise & ~cur_mode;

  // limit dac steering from output state, mode and selector bits
  always_comb
  begin
    idac_d = `OPLC_CODE_MIN;
    vdac_d = `OPLC_CODE_MIN;
    if (out_on)
    begin
      // output on: full scale unless the mode's byte fixes a limit
      idac_d = `OPLC_CODE_MAX;
      vdac_d = `OPLC_CODE_MAX;
      if (!cur_mode && curr_err_q[`OPLC_BIT_FIXED_LIMIT])
        idac_d = on_curr_q;
      if (cur_mode && volt_err_q[`OPLC_BIT_FIXED_LIMIT])
        vdac_d = on_volt_q;
    end
    else
    begin
      // output off: maximum forces come last but act in the opposite mode to the off code of the same dac
      if (!cur_mode && off_sel_q[`OPLC_SEL_IOFF])
        idac_d = off_curr_q;
      if (cur_mode && off_sel_q[`OPLC_SEL_VOFF])
        vdac_d = off_volt_q;
      if (!cur_mode && off_sel_q[`OPLC_SEL_VMAX])
        vdac_d = `OPLC_CODE_MAX;
      if (cur_mode && off_sel_q[`OPLC_SEL_IMAX])
        idac_d = `OPLC_CODE_MAX;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      idac_q <= `OPLC_CODE_MIN;
      vdac_q <= `OPLC_CODE_MIN;
    end
    else
    begin
      idac_q <= idac_d;
      vdac_q <= vdac_d;
    end
  end

  // power-up and reset value of the event status enable register
  always_comb
  begin
    if (curr_err_q[`OPLC_BIT_ESE_INIT] && curr_err_q[`OPLC_BIT_ESR_EN])
      ese_d = `OPLC_ESE_WITH_PROT;
    else
      ese_d = `OPLC_ESE_PLAIN;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      ese_q <= `OPLC_ESE_PLAIN;
    else
      ese_q <= ese_d;
  end

  // error reporting and output shutdown; a current protect error keeps
  // its number when both protect errors land in one cycle
  always_comb
  begin
    esr_d = ip_det & curr_err_q[`OPLC_BIT_ESR_EN];
    errp_d = 1'b0;
    errnum_d = errnum_q;
    if (ip_det && curr_err_q[`OPLC_BIT_ERR_MSG])
    begin
      errp_d = 1'b1;
      errnum_d = `OPLC_ERRNUM_CURR;
    end
    else if (vp_det && volt_err_q[`OPLC_BIT_ERR_MSG])
    begin
      errp_d = 1'b1;
      errnum_d = `OPLC_ERRNUM_VOLT;
    end
    deverr_d = (im_det & curr_err_q[`OPLC_BIT_MEAS_ERR])
             | (vm_det & volt_err_q[`OPLC_BIT_MEAS_ERR]);
    off_d = (ip_det & curr_err_q[`OPLC_BIT_PROT_OFF])
          | (vp_det & volt_err_q[`OPLC_BIT_PROT_OFF])
          | (im_det & curr_err_q[`OPLC_BIT_MEAS_OFF])
          | (vm_det & volt_err_q[`OPLC_BIT_MEAS_ERR]
             & volt_err_q[`OPLC_BIT_MEAS_OFF]);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      esr_q <= 1'b0;
      errp_q <= 1'b0;
      errnum_q <= 10'h000;
      deverr_q <= 1'b0;
      off_q <= 1'b0;
    end
    else
    begin
      esr_q <= esr_d;
      errp_q <= errp_d;
      errnum_q <= errnum_d;
      deverr_q <= deverr_d;
      off_q <= off_d;
    end
  end

  assign cfg_rdata = rdata_q;
  assign cfg_rvalid = rvalid_q;
  assign curr_limit_dac = idac_q;
  assign volt_limit_dac = vdac_q;
  assign ese_init = ese_q;
  assign esr_curr_prot = esr_q;
  assign error_pulse = errp_q;
  assign error_number = errnum_q;
  assign device_error = deverr_q;
  assign force_output_off = off_q;
endmodule : oplc_core

/* File: rtl/oplc_defs.svh */
// constants for the output protection and limit configuration block
`ifndef OPLC_DEFS_SVH
`define OPLC_DEFS_SVH

`define OPLC_REG_CURR_ERR 3'h0
`define OPLC_REG_VOLT_ERR 3'h1
`define OPLC_REG_OFF_CURR 3'h2
`define OPLC_REG_OFF_VOLT 3'h3
`define OPLC_REG_ON_CURR 3'h4
`define OPLC_REG_ON_VOLT 3'h5
`define OPLC_REG_OFF_SEL 3'h6
`define OPLC_BIT_FIXED_LIMIT 7
`define OPLC_BIT_PROT_EN 6
`define OPLC_BIT_ESR_EN 5
`define OPLC_BIT_ESE_INIT 4
`define OPLC_BIT_ERR_MSG 3
`define OPLC_BIT_PROT_OFF 2
`define OPLC_BIT_MEAS_ERR 1
`define OPLC_BIT_MEAS_OFF 0
`define OPLC_SEL_VMAX 0
`define OPLC_SEL_IMAX 1
`define OPLC_SEL_IOFF 4
`define OPLC_SEL_VOFF 3
`define OPLC_ESE_WITH_PROT 8'h48
`define OPLC_ESE_PLAIN 8'h08
`define OPLC_ESE_PROT_BIT 3
`define OPLC_ERRNUM_CURR 10'h12F
`define OPLC_ERRNUM_VOLT 10'h130
`define OPLC_CODE_STD_CURR 8'h80
`define OPLC_CODE_STD_VOLT 8'h00
`define OPLC_CODE_MIN 8'h00
`define OPLC_CODE_MAX 8'hFF

`endif

/* File: rtl/oplc_pkg.sv */
// types for the output protection and limit configuration block
package oplc_pkg;
  typedef logic [2:0] oplc_addr_type;
  typedef logic [7:0] oplc_byte_type;
  typedef logic [9:0] oplc_errnum_type;
endpackage : oplc_pkg

/* File: tb/oplc_properties.sv */
// concurrent checks on the limit configuration block ports
`timescale 1ns/10ps
module oplc_properties
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire oplc_pkg::oplc_addr_type cfg_addr,
  input wire oplc_pkg::oplc_byte_type cfg_wdata,
  input wire logic cfg_rvalid,
  input wire logic current_mode_pin,
  input wire logic curr_over_prot_pin,
  input wire logic volt_over_prot_pin,
  input wire logic curr_meas_err_pin,
  input wire logic volt_meas_err_pin,
  input wire oplc_pkg::oplc_byte_type ese_init,
  input wire logic esr_curr_prot,
  input wire logic error_pulse,
  input wire oplc_pkg::oplc_errnum_type error_number,
  input wire logic device_error,
  input wire logic force_output_off
);
  import oplc_pkg::*;
  oplc_byte_type cur_q;
  oplc_byte_type cur_d;
  oplc_byte_type vol_q;
  oplc_byte_type vol_d;
  // shadow of the two error-control bytes
  always_comb
  begin
    cur_d = (cfg_wr && cfg_addr == 3'h0) ? cfg_wdata : cur_q;
    vol_d = (cfg_wr && cfg_addr == 3'h1) ? cfg_wdata : vol_q;
  end
  always_ff @(posedge clk)
  begin
    cur_q <= rst ? 8'h00 : cur_d;
    vol_q <= rst ? 8'h00 : vol_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // protection events that detection lets through
  sequence s_curr_evt;
    $rose(curr_over_prot_pin) && cur_q[6];
  endsequence
  sequence s_volt_evt;
    $rose(volt_over_prot_pin) && vol_q[6];
  endsequence
  // measurement errors in the matching mode with the device error bit set
  sequence s_curr_meas_evt;
    $rose(curr_meas_err_pin) && current_mode_pin && cur_q[1];
  endsequence
  sequence s_volt_meas_evt;
    $rose(volt_meas_err_pin) && !current_mode_pin && vol_q[1];
  endsequence
  a_read_answer: assert property (cfg_rvalid == $past(cfg_rd))
    else $error("read answer out of step");
  a_curr_number: assert property (s_curr_evt ##0 cur_q[3] |->
    ##[3:5] (error_pulse && error_number == 10'h12F))
    else $error("current error number missing");
  a_curr_off: assert property (s_curr_evt ##0 cur_q[2] |-> ##[3:5] force_output_off)
    else $error("current protect turn-off missing");
  a_esr_event: assert property (s_curr_evt ##0 cur_q[5] |-> ##[3:5] esr_curr_prot)
    else $error("status event missing");
  a_volt_number: assert property (s_volt_evt ##0 vol_q[3] |->
    ##[3:5] (error_pulse && error_number == 10'h130))
    else $error("voltage error number missing");
  a_volt_off: assert property (s_volt_evt ##0 vol_q[2] |-> ##[3:5] force_output_off)
    else $error("voltage protect turn-off missing");
  a_ese_load: assert property ((cur_q[5] && cur_q[4]) [*4] |-> ese_init == 8'h48)
    else $error("enable init value wrong");
  a_curr_meas: assert property (s_curr_meas_evt |-> ##[3:5] device_error)
    else $error("current device error missing");
  a_volt_meas: assert property (s_volt_meas_evt |-> ##[3:5] device_error)
    else $error("voltage device error missing");
  a_volt_meas_off: assert property (s_volt_meas_evt ##0 vol_q[0] |->
    ##[3:5] force_output_off)
    else $error("voltage measure turn-off missing");
endmodule : oplc_properties

bind oplc_core oplc_properties u_props (.clk(clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
  .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rvalid(cfg_rvalid),
  .current_mode_pin(current_mode_pin), .curr_over_prot_pin(curr_over_prot_pin),
  .volt_over_prot_pin(volt_over_prot_pin), .curr_meas_err_pin(curr_meas_err_pin),
  .volt_meas_err_pin(volt_meas_err_pin), .ese_init(ese_init), .esr_curr_prot(esr_curr_prot),
  .error_pulse(error_pulse), .error_number(error_number), .device_error(device_error),
  .force_output_off(force_output_off));

/* File: tb/oplc_host.sv */
// host model issuing one-byte register accesses
`timescale 1ns/10ps
module oplc_host
(
  input wire logic clk,
  output logic cfg_wr,
  output logic cfg_rd,
  output oplc_pkg::oplc_addr_type cfg_addr,
  output oplc_pkg::oplc_byte_type cfg_wdata
);
  import oplc_pkg::*;
  oplc_byte_type exp_q [$];
  // idle bus at time zero
  initial
  begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 3'h0;
    cfg_wdata = 8'h00;
  end
  // one strobe cycle; a read notes its expected byte
  task automatic acc(logic w, oplc_addr_type ad, oplc_byte_type d);
    @(negedge clk);
    cfg_wr = w;
    cfg_rd = !w;
    cfg_addr = ad;
    cfg_wdata = d;
    if (!w)
      exp_q.push_back(d);
    @(negedge clk);
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = ~ad;
    cfg_wdata = ~d;
  endtask : acc
endmodule : oplc_host

/* File: tb/oplc_core_tb.sv */
// self-checking bench for the limit configuration block
`timescale 1ns/10ps
module oplc_core_tb;
  import oplc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic on_p = 1'b0;
  logic cm_p = 1'b0;
  logic [3:0] ev = 4'h0;
  logic wr, rd, rv, ep, de, fo, esr;
  oplc_addr_type a;
  oplc_byte_type wd, rdat, idac, vdac, ese;
  oplc_errnum_type num;
  int n_errors = 0;
  int compares = 0;
  int seed = 9235;
  int nde = 0;
  int nfo = 0;
  int nep = 0;
  int nesr = 0;
  oplc_byte_type m [8];
  localparam oplc_byte_type CFG [6] = '{8'h80, 8'h80, 8'h55, 8'h66, 8'h33, 8'h44};
  always #4 clk = ~clk;
  oplc_host host (.clk(clk), .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(a), .cfg_wdata(wd));
  oplc_core DUT (.clk(clk), .rst(rst), .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(a), .cfg_wdata(wd),
    .cfg_rdata(rdat), .cfg_rvalid(rv), .output_on_pin(on_p), .current_mode_pin(cm_p),
    .curr_over_prot_pin(ev[0]), .volt_over_prot_pin(ev[1]), .curr_meas_err_pin(ev[2]),
    .volt_meas_err_pin(ev[3]), .curr_limit_dac(idac), .volt_limit_dac(vdac), .ese_init(ese),
    .esr_curr_prot(esr), .error_pulse(ep), .error_number(num), .device_error(de),
    .force_output_off(fo));
  task automatic chk(string s, logic [9:0] e, logic [9:0] g);
    compares++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", s, e, g);
      n_errors++;
    end
  endtask : chk
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic fire(int k);
    ev[k] = 1'b1;
    repeat (8) @(negedge clk);
    ev[k] = 1'b0;
    repeat (4) @(negedge clk);
  endtask : fire
  task automatic dac(logic o, logic c, oplc_byte_type s, oplc_byte_type ei, oplc_byte_type ve);
    on_p = o;
    cm_p = c;
    host.acc(1'b1, 3'h6, s);
    repeat (5) @(negedge clk);
    chk("curr_limit_dac", ei, idac);
    chk("volt_limit_dac", ve, vdac);
  endtask : dac
  // read answers against the oldest note; device errors counted
  always @(negedge clk)
  begin
    if (rv === 1'b1)
      chk("cfg_rdata", host.exp_q.pop_front(), rdat);
    if (de === 1'b1)
      nde++;
    if (fo === 1'b1)
      nfo++;
    if (ep === 1'b1)
      nep++;
    if (esr === 1'b1)
      nesr++;
  end
  // watchdog
  initial
  begin
    repeat (3000) @(posedge clk);
    n_errors++;
    conclude();
  end
  // main sequence
  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++)
      host.acc(1'b0, i[2:0], (i == 2 || i == 4) ? 8'h80 : 8'h00);
    chk("ese_init", 10'h008, ese);
    for (int i = 0; i < 16; i++)
    begin
      m[i % 8] = 8'($random(seed));
      host.acc(1'b1, i[2:0], m[i % 8]);
    end
    for (int i = 0; i < 8; i++)
      host.acc(1'b0, i[2:0], i == 7 ? 8'h00 : i == 6 ? m[6] & 8'h1F : m[i]);
    for (int i = 0; i < 6; i++)
      host.acc(1'b1, i[2:0], CFG[i]);
    dac(1'b1, 1'b0, 8'h00, 8'h33, 8'hFF);
    dac(1'b1, 1'b1, 8'h00, 8'hFF, 8'h44);
    dac(1'b0, 1'b0, 8'h10, 8'h55, 8'h00);
    dac(1'b0, 1'b1, 8'h10, 8'h00, 8'h00);
    dac(1'b0, 1'b1, 8'h08, 8'h00, 8'h66);
    dac(1'b0, 1'b0, 8'h11, 8'h55, 8'hFF);
    dac(1'b0, 1'b1, 8'h0A, 8'hFF, 8'h66);
    cm_p = 1'b0;
    host.acc(1'b1, 3'h1, 8'h4F);
    fire(1);
    chk("error_number", 10'h130, num);
    chk("force_output_off count", 10'h001, nfo[9:0]);
    host.acc(1'b1, 3'h1, 8'h0F);
    fire(1);
    chk("error_pulse count", 10'h001, nep[9:0]);
    host.acc(1'b1, 3'h0, 8'h3C);
    fire(0);
    chk("error_number", 10'h130, num);
    fire(2);
    fire(3);
    chk("device_error count", 10'h001, nde[9:0]);
    chk("force_output_off count", 10'h002, nfo[9:0]);
    host.acc(1'b1, 3'h0, 8'h7E);
    fire(0);
    chk("error_number", 10'h12F, num);
    chk("error_pulse count", 10'h002, nep[9:0]);
    chk("esr_curr_prot count", 10'h001, nesr[9:0]);
    chk("force_output_off count", 10'h003, nfo[9:0]);
    chk("ese_init", 8'h48, ese);
    cm_p = 1'b1;
    repeat (4) @(negedge clk);
    fire(2);
    chk("device_error count", 10'h002, nde[9:0]);
    chk("force_output_off count", 10'h003, nfo[9:0]);
    host.acc(1'b1, 3'h0, 8'h03);
    fire(2);
    chk("device_error count", 10'h003, nde[9:0]);
    chk("force_output_off count", 10'h004, nfo[9:0]);
    dac(1'b1, 1'b0, 8'h00, 8'hFF, 8'hFF);
    conclude();
  end
endmodule : oplc_core_tb
